// File: hw/mbc_motor_brake_ctrl.sv
// mbc_motor_brake_ctrl: standstill current reduction, brake sequencing with
// brake pwm, and motor current readout behind an object dictionary port.
// assumes all inputs are synchronous to clk and currents arrive as peak mA.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Reduction applies only with the enable bit set, open loop, and standstill.
// - A setting from zero up to below rated current is the standstill limit in mA rms.
// - A setting from -1 to -100 gives rated times (setting plus 100) over 100.
// - After standstill the close-brake idle time passes before the brake closes.
// - After the brake closes the shutdown idle time passes before current goes off.
// - After current comes on the open-brake delay passes before the brake opens.
// - After the brake opens the start delay passes before the run state.
// - The brake output is a pwm at the set frequency, accepted as 0 or 50 to 2000 Hz.
// - The brake pwm duty is the set percentage, accepted as 0 or 2 to 100.
// - Current readings other than the total are peak values in mA.
// - Field, torque, alpha and beta readings sit at subindices 1 to 4.
// - Field and torque readings show zero unless closed loop is active.
// - In open loop the total equals the alpha-beta magnitude over root two.
// - In closed loop the total takes the sign of the torque current.
// - The brake timing entry count reads six.
// - Reduction starts only after standstill has lasted the idle time in ms.
module mbc_motor_brake_ctrl
	import mbc_pkg::*;
#(
	parameter int TICK_CYCLES = MS_CYCLES,
	parameter int PWM_CLK_HZ = CLK_HZ
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// object dictionary access
	input wire logic od_req,
	input wire logic od_wr,
	input wire logic [15:0] od_index,
	input wire logic [7:0] od_sub,
	input wire logic [31:0] od_wdata,
	output logic od_ack,
	output logic od_abort,
	output logic [31:0] od_rdata,
	// drive status
	input wire logic reduction_en,
	input wire logic closed_loop,
	input wire logic standstill,
	input wire logic enable_req,
	input wire logic [31:0] rated_current,
	// measured currents
	input wire logic [31:0] meas_field,
	input wire logic [31:0] meas_torque,
	input wire logic [31:0] meas_alpha,
	input wire logic [31:0] meas_beta,
	// drive control
	output logic [31:0] current_limit,
	output logic reduction_active,
	output logic current_on,
	output logic brake_open,
	output logic brake_pwm,
	output logic run_state
);
	localparam logic [31:0] DIV_LAST = 32'(TICK_CYCLES - 1);

	typedef struct packed {
		mbc_brake_e st;
		logic [31:0] div;
		logic [31:0] cnt;
		logic [31:0] ss;
		logic [31:0] idle;
		logic signed [31:0] red_set;
		logic [31:0] t_close;
		logic [31:0] t_pwroff;
		logic [31:0] t_open;
		logic [31:0] t_run;
		logic [31:0] freq;
		logic [31:0] duty;
		logic signed [31:0] field;
		logic signed [31:0] torque;
		logic signed [31:0] alpha;
		logic signed [31:0] beta;
		logic signed [31:0] total;
		logic ack;
		logic abort;
		logic [31:0] rdata;
		logic red;
		logic [31:0] limit;
	} mbc_ctrl_s;

	mbc_ctrl_s q, n;
	logic tick;
	logic expired;
	logic red;
	logic signed [63:0] ax;
	logic signed [63:0] bx;
	logic [63:0] radicand;
	logic [48:0] scaled;
	logic [31:0] mag;
	logic sq_busy;
	logic sq_done;
	logic [31:0] sq_root;

	function automatic logic [31:0] mbc_reduce(input logic signed [31:0] set,
		input logic [31:0] rated);
		logic [39:0] prod;
		prod = 40'(rated) * 40'(unsigned'(set + PCT_FULL));
		if (set >= 0 && unsigned'(set) < rated)
			return unsigned'(set);
		else if (set <= -1 && set >= PCT_MIN)
			return 32'(prod / PCT_DIV);
		else
			return rated;
	endfunction : mbc_reduce

	function automatic logic [31:0] mbc_step(input logic [31:0] cnt, input logic tk);
		return tk ? cnt - 32'h0000_0001 : cnt;
	endfunction : mbc_step

	always_comb
	begin
		n = q;
		n.ack = 1'b0;
		n.abort = 1'b0;
		tick = (q.div == DIV_LAST);
		n.div = tick ? '0 : q.div + 32'h0000_0001;
		expired = (q.cnt == '0);
		case (q.st)
			ST_OFF:
				if (enable_req)
				begin
					n.st = ST_ON_WAIT;
					n.cnt = q.t_open;
					n.div = '0;
				end
			ST_ON_WAIT:
				if (expired)
				begin
					n.st = ST_OPEN_WAIT;
					n.cnt = q.t_run;
					n.div = '0;
				end
				else
					n.cnt = mbc_step(q.cnt, tick);
			ST_OPEN_WAIT:
				if (expired)
					n.st = ST_RUN;
				else
					n.cnt = mbc_step(q.cnt, tick);
			ST_RUN:
				if (!enable_req && standstill)
				begin
					n.st = ST_CLOSE_WAIT;
					n.cnt = q.t_close;
					n.div = '0;
				end
			ST_CLOSE_WAIT:
				if (enable_req)
					n.st = ST_RUN;
				else if (expired)
				begin
					n.st = ST_PWROFF_WAIT;
					n.cnt = q.t_pwroff;
					n.div = '0;
				end
				else
					n.cnt = mbc_step(q.cnt, tick);
			ST_PWROFF_WAIT:
				if (expired)
					n.st = ST_OFF;
				else
					n.cnt = mbc_step(q.cnt, tick);
			default:
				n.st = ST_OFF;
		endcase

		// standstill time in ms, saturating
		if (!standstill)
			n.ss = '0;
		else if (tick && q.ss != '1)
			n.ss = q.ss + 32'h0000_0001;
		red = reduction_en && !closed_loop && standstill && (q.ss >= q.idle);
		n.red = red;
		n.limit = red ? mbc_reduce(q.red_set, rated_current) : rated_current;

		// readings, taken as peak mA
		n.field = closed_loop ? meas_field : '0;
		n.torque = closed_loop ? meas_torque : '0;
		n.alpha = meas_alpha;
		n.beta = meas_beta;
		ax = 64'(q.alpha);
		bx = 64'(q.beta);
		radicand = unsigned'(ax * ax) + unsigned'(bx * bx);
		scaled = 49'(sq_root) * 49'(INV_SQRT2_Q16);
		mag = scaled[47:16];
		if (sq_done)
			n.total = (closed_loop && q.torque < 0) ? -signed'(mag) : signed'(mag);

		if (od_req)
		begin
			n.ack = 1'b1;
			n.rdata = '0;
			if (od_wr)
			begin
				case (od_index)
					OD_IDLE_TIME:
						n.idle = od_wdata;
					OD_RED_SET:
						n.red_set = od_wdata;
					OD_BRAKE:
						case (od_sub)
							SUB_CLOSE:
								n.t_close = od_wdata;
							SUB_PWROFF:
								n.t_pwroff = od_wdata;
							SUB_OPEN:
								n.t_open = od_wdata;
							SUB_RUN:
								n.t_run = od_wdata;
							SUB_FREQ:
								if (od_wdata == '0 || (od_wdata >= FREQ_MIN && od_wdata <= FREQ_MAX))
									n.freq = od_wdata;
								else
									n.abort = 1'b1;
							SUB_DUTY:
								if (od_wdata == '0 || (od_wdata >= DUTY_MIN && od_wdata <= DUTY_MAX))
									n.duty = od_wdata;
								else
									n.abort = 1'b1;
							default:
								n.abort = 1'b1;
						endcase
					default:
						n.abort = 1'b1;
				endcase
			end
			else
			begin
				case (od_index)
					OD_IDLE_TIME:
						n.rdata = q.idle;
					OD_RED_SET:
						n.rdata = q.red_set;
					OD_BRAKE:
						case (od_sub)
							SUB_COUNT:
								n.rdata = 32'(BRAKE_COUNT);
							SUB_CLOSE:
								n.rdata = q.t_close;
							SUB_PWROFF:
								n.rdata = q.t_pwroff;
							SUB_OPEN:
								n.rdata = q.t_open;
							SUB_RUN:
								n.rdata = q.t_run;
							SUB_FREQ:
								n.rdata = q.freq;
							SUB_DUTY:
								n.rdata = q.duty;
							default:
								n.abort = 1'b1;
						endcase
					OD_CURR:
						case (od_sub)
							SUB_COUNT:
								n.rdata = 32'(CURR_COUNT);
							SUB_FIELD:
								n.rdata = q.field;
							SUB_TORQUE:
								n.rdata = q.torque;
							SUB_ALPHA:
								n.rdata = q.alpha;
							SUB_BETA:
								n.rdata = q.beta;
							SUB_TOTAL:
								n.rdata = q.total;
							default:
								n.abort = 1'b1;
						endcase
					default:
						n.abort = 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.st <= ST_OFF;
			q.idle <= RST_IDLE_TIME;
			q.red_set <= RST_RED_SET;
			q.t_close <= RST_CLOSE;
			q.t_pwroff <= RST_PWROFF;
			q.t_open <= RST_OPEN;
			q.t_run <= RST_RUN;
			q.freq <= RST_FREQ;
			q.duty <= RST_DUTY;
		end
		else
			q <= n;
	end

	// magnitude runs continuously on the latched alpha and beta
	mbc_isqrt u_isqrt (
		.clk(clk),
		.rst_n(rst_n),
		.start(!sq_busy),
		.radicand(radicand),
		.busy(sq_busy),
		.done(sq_done),
		.root(sq_root)
	);

	mbc_pwm #(
		.CLK_FREQ(PWM_CLK_HZ)
	) u_pwm (
		.clk(clk),
		.rst_n(rst_n),
		.enable(brake_open),
		.freq(q.freq),
		.duty(q.duty),
		.pwm_out(brake_pwm)
	);

	assign od_ack = q.ack;
	assign od_abort = q.abort;
	assign od_rdata = q.rdata;
	assign current_limit = q.limit;
	assign reduction_active = q.red;
	assign current_on = (q.st != ST_OFF);
	assign brake_open = (q.st == ST_OPEN_WAIT) || (q.st == ST_RUN) || (q.st == ST_CLOSE_WAIT);
	assign run_state = (q.st == ST_RUN);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_red_gate;
		reduction_active |-> $past(reduction_en) && !$past(closed_loop) && $past(standstill);
	endproperty
	a_red_gate: assert property (p_red_gate) else $error("reduction without its conditions");

	property p_red_idle;
		reduction_active |-> $past(q.ss) >= $past(q.idle);
	endproperty
	a_red_idle: assert property (p_red_idle) else $error("reduction before idle time");

	property p_abs_limit;
		reduction_active && $past(q.red_set) >= 0 && unsigned'($past(q.red_set)) < $past(rated_current)
			|-> current_limit == unsigned'($past(q.red_set));
	endproperty
	a_abs_limit: assert property (p_abs_limit) else $error("absolute limit wrong");

	property p_pct_zero;
		reduction_active && $past(q.red_set) == PCT_MIN |-> current_limit == '0;
	endproperty
	a_pct_zero: assert property (p_pct_zero) else $error("percent limit wrong");

	property p_close_order;
		q.st == ST_PWROFF_WAIT && $past(q.st) != ST_PWROFF_WAIT
			|-> $past(q.st) == ST_CLOSE_WAIT && $past(q.cnt) == '0;
	endproperty
	a_close_order: assert property (p_close_order) else $error("brake closed early");

	property p_off_order;
		!current_on && $past(current_on) |-> $past(q.st) == ST_PWROFF_WAIT && $past(q.cnt) == '0;
	endproperty
	a_off_order: assert property (p_off_order) else $error("current off early");

	property p_open_order;
		brake_open && !$past(brake_open) |-> $past(q.st) == ST_ON_WAIT && $past(q.cnt) == '0;
	endproperty
	a_open_order: assert property (p_open_order) else $error("brake opened early");

	property p_run_order;
		$rose(run_state) |-> $past(q.st) inside {ST_OPEN_WAIT, ST_CLOSE_WAIT};
	endproperty
	a_run_order: assert property (p_run_order) else $error("run entered early");

	property p_pwm_idle;
		!brake_open [*2] |-> !brake_pwm;
	endproperty
	a_pwm_idle: assert property (p_pwm_idle) else $error("pwm with brake closed");

	property p_duty_reject;
		od_req && od_wr && od_index == OD_BRAKE && od_sub == SUB_DUTY && od_wdata == DUTY_MIN - 1
			|=> od_abort ##1 q.duty == $past(q.duty, 2);
	endproperty
	a_duty_reject: assert property (p_duty_reject) else $error("bad duty accepted");

	property p_field_zero;
		!closed_loop |=> q.field == '0 && q.torque == '0;
	endproperty
	a_field_zero: assert property (p_field_zero) else $error("field shown in open loop");

	property p_total_sign;
		sq_done && closed_loop && q.torque < 0 |=> q.total <= 0;
	endproperty
	a_total_sign: assert property (p_total_sign) else $error("total sign wrong");

	property p_count_six;
		od_req && !od_wr && od_index == OD_BRAKE && od_sub == SUB_COUNT
			|=> od_ack && !od_abort && od_rdata == 32'h0000_0006;
	endproperty
	a_count_six: assert property (p_count_six) else $error("entry count wrong");

	c_run: cover property ($rose(run_state));
	c_reduce: cover property ($rose(reduction_active));
	c_shutdown: cover property (q.st == ST_PWROFF_WAIT ##1 q.st == ST_OFF);
	c_abort: cover property (od_abort);
endmodule : mbc_motor_brake_ctrl
`default_nettype wire

// File: hw/mbc_pkg.sv
// mbc_pkg: object indices, subindices, reset values, limits and timing for
// the motor brake and current control block.
// assumes a single 100 MHz system clock.
package mbc_pkg;

	// object dictionary indices
	localparam logic [15:0] OD_IDLE_TIME = 16'h2036;
	localparam logic [15:0] OD_RED_SET = 16'h2037;
	localparam logic [15:0] OD_BRAKE = 16'h2038;
	localparam logic [15:0] OD_CURR = 16'h2039;

	// subindices of the brake timing array
	localparam logic [7:0] SUB_COUNT = 8'h00;
	localparam logic [7:0] SUB_CLOSE = 8'h01;
	localparam logic [7:0] SUB_PWROFF = 8'h02;
	localparam logic [7:0] SUB_OPEN = 8'h03;
	localparam logic [7:0] SUB_RUN = 8'h04;
	localparam logic [7:0] SUB_FREQ = 8'h05;
	localparam logic [7:0] SUB_DUTY = 8'h06;

	// subindices of the current readout array
	localparam logic [7:0] SUB_FIELD = 8'h01;
	localparam logic [7:0] SUB_TORQUE = 8'h02;
	localparam logic [7:0] SUB_ALPHA = 8'h03;
	localparam logic [7:0] SUB_BETA = 8'h04;
	localparam logic [7:0] SUB_TOTAL = 8'h05;

	// entry counts and reset values
	localparam logic [7:0] BRAKE_COUNT = 8'h06;
	localparam logic [7:0] CURR_COUNT = 8'h05;
	localparam logic [31:0] RST_IDLE_TIME = 32'h0000_03e8;
	localparam logic [31:0] RST_RED_SET = 32'h0fff_ffce;
	localparam logic [31:0] RST_CLOSE = 32'h0000_03e8;
	localparam logic [31:0] RST_PWROFF = 32'h0000_03e8;
	localparam logic [31:0] RST_OPEN = 32'h0000_03e8;
	localparam logic [31:0] RST_RUN = 32'h0000_0000;
	localparam logic [31:0] RST_FREQ = 32'h0000_0000;
	localparam logic [31:0] RST_DUTY = 32'h0000_0000;

	// accepted pwm settings and percentage arithmetic
	localparam logic [31:0] FREQ_MIN = 32'h0000_0032;
	localparam logic [31:0] FREQ_MAX = 32'h0000_07d0;
	localparam logic [31:0] DUTY_MIN = 32'h0000_0002;
	localparam logic [31:0] DUTY_MAX = 32'h0000_0064;
	localparam logic signed [31:0] PCT_FULL = 32'sh0000_0064;
	localparam logic signed [31:0] PCT_MIN = -32'sh0000_0064;
	localparam logic [39:0] PCT_DIV = 40'h00_0000_0064;
	localparam logic [16:0] INV_SQRT2_Q16 = 17'h0_b505;

	// timing
	localparam int CLK_HZ = 32'h05f5_e100;
	localparam int CLK_PERIOD_NS = 32'h0000_000a;
	localparam int MS_NS = 32'h000f_4240;
	localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

	// brake sequencer states
	typedef enum logic [5:0] {
		ST_OFF = 6'h01,
		ST_ON_WAIT = 6'h02,
		ST_OPEN_WAIT = 6'h04,
		ST_RUN = 6'h08,
		ST_CLOSE_WAIT = 6'h10,
		ST_PWROFF_WAIT = 6'h20
	} mbc_brake_e;

endpackage : mbc_pkg

// File: hw/mbc_isqrt.sv
// mbc_isqrt: bit-serial integer square root, one result bit per clock.
// assumes start is only acted on while idle; root holds until the next done.
`timescale 1ns/1ps
`default_nettype none
module mbc_isqrt
	import mbc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// request
	input wire logic start,
	input wire logic [63:0] radicand,
	// result
	output logic busy,
	output logic done,
	output logic [31:0] root
);
	typedef struct packed {
		logic [63:0] op;
		logic [63:0] res;
		logic [63:0] one;
		logic busy;
		logic done;
		logic [31:0] root;
	} mbc_sq_s;

	mbc_sq_s q, n;
	logic [63:0] trial;

	always_comb
	begin
		n = q;
		n.done = 1'b0;
		trial = q.res + q.one;
		if (!q.busy)
		begin
			if (start)
			begin
				n.op = radicand;
				n.res = '0;
				n.one = 64'h4000_0000_0000_0000;
				n.busy = 1'b1;
			end
		end
		else if (q.one == '0)
		begin
			n.busy = 1'b0;
			n.done = 1'b1;
			n.root = q.res[31:0];
		end
		else
		begin
			if (q.op >= trial)
			begin
				n.op = q.op - trial;
				n.res = (q.res >> 1) + q.one;
			end
			else
			begin
				n.res = q.res >> 1;
			end
			n.one = q.one >> 2;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= n;
	end

	assign busy = q.busy;
	assign done = q.done;
	assign root = q.root;
endmodule : mbc_isqrt
`default_nettype wire

// File: hw/mbc_pwm.sv
// mbc_pwm: brake output pwm by phase accumulation at the system clock.
// assumes freq and duty were range checked; either at zero gives a steady level.
`timescale 1ns/1ps
`default_nettype none
module mbc_pwm
	import mbc_pkg::*;
#(
	parameter int CLK_FREQ = CLK_HZ
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic enable,
	input wire logic [31:0] freq,
	input wire logic [31:0] duty,
	// output
	output logic pwm_out
);
	localparam logic [31:0] WRAP = 32'(CLK_FREQ);

	typedef struct packed {
		logic [31:0] phase;
		logic out;
	} mbc_pwm_s;

	mbc_pwm_s q, n;
	logic [31:0] sum;

	always_comb
	begin
		n = q;
		sum = q.phase + freq;
		n.phase = (sum >= WRAP) ? sum - WRAP : sum;
		if (freq == '0 || duty == '0)
			n.out = enable;
		else
			n.out = enable && (40'(q.phase) * PCT_DIV < 40'(WRAP) * 40'(duty));
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= n;
	end

	assign pwm_out = q.out;
endmodule : mbc_pwm
`default_nettype wire

// File: tb/mbc_od_master.sv
// mbc_od_master: object dictionary master, one pulsed access at a time.
// assumes the answer stands in the cycle after the request edge.
`timescale 1ns/1ps
`default_nettype none
module mbc_od_master
(
	// clock
	input wire logic clk,
	// request
	output logic od_req,
	output logic od_wr,
	output logic [15:0] od_index,
	output logic [7:0] od_sub,
	output logic [31:0] od_wdata,
	// answer
	input wire logic od_ack,
	input wire logic od_abort,
	input wire logic [31:0] od_rdata
);
	initial
	begin
		od_req = 1'b0;
		od_wr = 1'b0;
		od_index = 16'h0000;
		od_sub = 8'h00;
		od_wdata = 32'h0000_0000;
	end
	task automatic access(input logic wr, input logic [15:0] ix, input logic [7:0] sb,
		input logic [31:0] wd, output logic ak, output logic ab, output logic [31:0] rd);
		@(negedge clk);
		od_req = 1'b1;
		od_wr = wr;
		od_index = ix;
		od_sub = sb;
		od_wdata = wd;
		@(negedge clk);
		ak = od_ack;
		ab = od_abort;
		rd = od_rdata;
		// released qualifiers are scrambled so a stale value is never trusted
		od_req = 1'b0;
		od_wr = ~wr;
		od_index = ~ix;
		od_sub = ~sb;
		od_wdata = ~wd;
	endtask : access
endmodule : mbc_od_master
`default_nettype wire

// File: tb/mbc_motor_brake_ctrl_test.sv
// mbc_motor_brake_ctrl_test: self-checking bench for the brake and current block.
// assumes a 4-cycle ms tick and a 100 kHz pwm reference clock.
`timescale 1ns/1ps
`default_nettype none
module mbc_motor_brake_ctrl_test
	import mbc_pkg::*;
;
	localparam int TK = 4;
	logic clk, rst_n, od_req, od_wr, od_ack, od_abort;
	logic [15:0] od_index;
	logic [7:0] od_sub;
	logic [31:0] od_wdata, od_rdata, rated, m_f, m_t, m_a, m_b, lim;
	logic red_en, cl, stand, en_req, red_act, cur_on, brk_open, brk_pwm, run;
	logic [3:0] sv;
	logic [31:0] pf [4] = '{32'h0000_0000, 32'h0000_0064, 32'h0000_00c8, 32'h0000_0032};
	logic [31:0] pd [4] = '{32'h0000_0032, 32'h0000_0019, 32'h0000_0064, 32'h0000_0002};
	int bad_count, comparisons;
	assign sv = {red_act, run, brk_open, cur_on};
	mbc_motor_brake_ctrl #(.TICK_CYCLES(TK), .PWM_CLK_HZ(100000)) i_dut (.clk(clk),
		.rst_n(rst_n), .od_req(od_req), .od_wr(od_wr), .od_index(od_index),
		.od_sub(od_sub), .od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort),
		.od_rdata(od_rdata), .reduction_en(red_en), .closed_loop(cl),
		.standstill(stand), .enable_req(en_req), .rated_current(rated),
		.meas_field(m_f), .meas_torque(m_t), .meas_alpha(m_a), .meas_beta(m_b),
		.current_limit(lim), .reduction_active(red_act), .current_on(cur_on),
		.brake_open(brk_open), .brake_pwm(brk_pwm), .run_state(run));
	mbc_od_master i_master (.clk(clk), .od_req(od_req), .od_wr(od_wr),
		.od_index(od_index), .od_sub(od_sub), .od_wdata(od_wdata), .od_ack(od_ack),
		.od_abort(od_abort), .od_rdata(od_rdata));
	initial clk = 1'b0;
	always #5 clk = ~clk;
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		comparisons++;
		if (seen !== ex)
		begin
			$display("ERROR %s expected %h seen %h", nm, ex, seen);
			bad_count++;
		end
	endtask : check
	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	task automatic od(input logic wr, input logic [15:0] ix, input logic [7:0] sb,
		input logic [31:0] wd, input logic ab, input logic [31:0] ex);
		logic k, a;
		logic [31:0] r;
		i_master.access(wr, ix, sb, wd, k, a, r);
		check("od_ack", {31'h0, k}, 32'h0000_0001);
		check("od_abort", {31'h0, a}, {31'h0, ab});
		if (!wr && !ab)
			check("od_rdata", r, ex);
	endtask : od
	// counts edges until the selected output reaches v
	task automatic wait_sig(input int s, input logic v, output int n);
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (sv[s] !== v && n < 4000);
		if (sv[s] !== v)
		begin
			bad_count++;
			complete_run();
		end
	endtask : wait_sig
	function automatic logic [31:0] exp_lim(input logic [31:0] rt, input logic signed [31:0] s);
		if (s >= 0 && s < $signed(rt))
			return s;
		if (s <= -1 && s >= -100)
			return 32'((64'(rt) * 64'(s + 100)) / 100);
		return rt;
	endfunction : exp_lim
	function automatic longint unsigned isq(input longint unsigned v);
		longint unsigned x = 0;
		for (int b = 31; b >= 0; b--)
			if ((x + (64'd1 << b)) * (x + (64'd1 << b)) <= v)
				x += 64'd1 << b;
		return x;
	endfunction : isq
	initial
	begin
		logic [31:0] r, t [4], cur;
		logic signed [31:0] s;
		logic k, a;
		int n, h;
		longint e, x, y;
		bad_count = 0;
		comparisons = 0;
		rst_n = 1'b0;
		{red_en, cl, stand, en_req} = 4'h0;
		rated = 32'h0000_03e8;
		{m_f, m_t, m_a, m_b} = 128'h0;
		void'($urandom(32'h09f3_1cc4));
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		od(0, 16'h2036, 8'h00, 0, 0, 32'h0000_03e8);
		od(0, 16'h2037, 8'h00, 0, 0, 32'h0fff_ffce);
		for (int i = 0; i < 7; i++)
			od(0, 16'h2038, 8'(i), 0, 0, i == 0 ? 6 : i < 4 ? 32'h0000_03e8 : 0);
		for (int i = 0; i < 6; i++)
			od(0, 16'h2039, 8'(i), 0, 0, i == 0 ? 5 : 0);
		od(0, 16'h2040, 8'h00, 0, 1, 0);
		od(0, 16'h2038, 8'h07, 0, 1, 0);
		od(1, 16'h2038, 8'h00, 32'h0000_0009, 1, 0);
		od(0, 16'h2038, 8'h00, 0, 0, 32'h0000_0006);
		od(1, 16'h2039, 8'h01, 32'h0000_0001, 1, 0);
		// pwm settings at both edges of the accepted ranges; a refusal keeps the old value
		cur = 0;
		foreach (pf[i])
		begin
			r = i[0] ? 32'h0000_0065 : 32'h0000_0001;
			od(1, 16'h2038, 8'h06, r, 1, 0);
			od(0, 16'h2038, 8'h06, 0, 0, cur);
			cur = pd[i];
			od(1, 16'h2038, 8'h06, cur, 0, 0);
		end
		od(1, 16'h2038, 8'h05, 32'h0000_0031, 1, 0);
		od(1, 16'h2038, 8'h05, 32'h0000_07d0, 0, 0);
		od(1, 16'h2038, 8'h05, 32'h0000_07d1, 1, 0);
		od(0, 16'h2038, 8'h05, 0, 0, 32'h0000_07d0);
		for (int i = 0; i < 4; i++)
		begin
			for (int j = 0; j < 4; j++)
			begin
				t[j] = $urandom_range(3);
				od(1, 16'h2038, 8'(j + 1), t[j], 0, 0);
			end
			od(1, 16'h2038, 8'h05, pf[i], 0, 0);
			od(1, 16'h2038, 8'h06, pd[i], 0, 0);
			@(negedge clk);
			en_req = 1'b1;
			wait_sig(0, 1, n);
			check("on_delay", n, 1);
			wait_sig(1, 1, n);
			check("open_delay", n, t[2] * TK + 1);
			wait_sig(2, 1, n);
			check("run_delay", n, t[3] * TK + 1);
			h = 0;
			repeat (2000)
			begin
				@(posedge clk);
				#1;
				h += brk_pwm;
			end
			e = (pf[i] == 0 || pd[i] == 0) ? 2000 : 20 * pd[i];
			check("pwm_high", h >= e - 4 && h <= e + 4, 1);
			@(negedge clk);
			en_req = 1'b0;
			stand = 1'b1;
			// a fresh enable during the close wait must return to run at once
			if (i[0])
			begin
				@(negedge clk);
				check("close_leave", run, 0);
				en_req = 1'b1;
				@(negedge clk);
				check("close_return", {run, brk_open}, 32'h0000_0003);
				en_req = 1'b0;
			end
			wait_sig(1, 0, n);
			check("close_delay", n, t[0] * TK + 2);
			wait_sig(0, 0, n);
			check("pwroff_delay", n, t[1] * TK + 1);
			@(negedge clk);
			stand = 1'b0;
		end
		red_en = 1'b1;
		od(1, 16'h2036, 8'h00, 32'h0000_0003, 0, 0);
		@(negedge clk);
		stand = 1'b1;
		wait_sig(3, 1, n);
		check("idle_window", n >= 2 * TK + 1 && n <= 3 * TK + 3, 1);
		for (int i = 0; i < 13; i++)
		begin
			rated = 1 + $urandom_range(4999);
			case (i % 4)
				0: s = $urandom_range(rated - 1);
				1: s = i == 1 ? -1 : i == 5 ? -100 : -1 - $urandom_range(99);
				2: s = rated;
				default: s = -101 - $urandom_range(999);
			endcase
			if (i == 12)
				s = -50;
			od(1, 16'h2037, 8'h00, s, 0, 0);
			repeat (3) @(negedge clk);
			check("reduced_limit", lim, exp_lim(rated, s));
			check("reduction_on", red_act, 1);
		end
		for (int i = 0; i < 3; i++)
		begin
			red_en = i != 0;
			cl = i == 1;
			stand = i != 2;
			repeat (3) @(negedge clk);
			check("limit_gate", lim, rated);
			check("reduction_gate", red_act, 0);
		end
		for (int i = 0; i < 8; i++)
		begin
			cl = i[0];
			m_f = $urandom_range(40000) - 20000;
			m_t = ($urandom_range(40000) - 20000) | 1;
			m_a = $urandom_range(40000) - 20000;
			m_b = $urandom_range(40000) - 20000;
			repeat (80) @(negedge clk);
			od(0, 16'h2039, 8'h01, 0, 0, cl ? m_f : 0);
			od(0, 16'h2039, 8'h02, 0, 0, cl ? m_t : 0);
			od(0, 16'h2039, 8'h03, 0, 0, m_a);
			od(0, 16'h2039, 8'h04, 0, 0, m_b);
			i_master.access(1'b0, 16'h2039, 8'h05, 32'h0000_0000, k, a, r);
			check("total_abort", a, 0);
			x = $signed(m_a);
			y = $signed(m_b);
			e = longint'((isq(x * x + y * y) * INV_SQRT2_Q16) >> 16);
			if (cl && m_t[31])
				e = -e;
			check("total", $signed(r) - e <= 1 && $signed(r) - e >= -1, 1);
		end
		complete_run();
	end
endmodule : mbc_motor_brake_ctrl_test
`default_nettype wire
